// ===== hdl/prioritized_vector_irq_controller.sv
// prioritized vectored interrupt controller, 24 sources plus watchdog
// assumes all inputs are synchronous to clk; core pulses are one cycle
`timescale 1ns/1ps

// Summary of operation
// R1: vector word: high byte at even address, low byte at next odd address.
// R2: reset 0002h, watchdog 0004h, illegal trap 0006h; reset and trap unmasked.
// R3: timer2 at 0008h down through ADC at 0016h, two bytes apart.
// R4: eight shared GPIO edge sources, pin7 at 0018h to pin0 at 0026h.
// R5: timer3 at 0028h, UART1 receive, UART1 transmit, DMA at 002Eh.
// R6: port C pins 3..0, both edges, vectors 0030h to 0036h.
// R7: watchdog, UARTs, I2C, SPI are level sources; the rest are pulses.
// R8: master enable sets on enable, return, or software write of 1.
// R9: master enable clears on disable, ack, write 0, reset, trap, illegal.
// R10: level 3 beats level 2, level 2 beats level 1.
// R11: within a level, lowest vector address wins.
// R12: reset, enabled watchdog and illegal trap always sit above all levels; the code offers only the watchdog vector, never 0002h or 0006h.
// R13: a one-cycle pulse is caught into a sticky pending bit.
// R14: ack clears a pulse source's pending bit until it pulses again.
// R15: software write of 0 clears a pulse source's pending bit.
// R16: ack never clears a level source's pending bit.
// R17: write 0 clears a level source one cycle; it sets again if still high.
// R18: software clears a level source at the peripheral first, then pending.
// R19: enable, priority and pending controls cover all but the watchdog.
// R20: enable high/low: 00 off, 01 level1, 10 level2, 11 level3.
// R21: request sets pending; forwarded only with master enable, else polled.
// R22: each shared GPIO vector takes port A or port D, set by a select.
// R23: pending and enable bits reset to 0.
// R24: winning vector offered and held stable until the core acknowledges.
// R25: a pulse in the same cycle as its clear wins.
module prioritized_vector_irq_controller
  import irq_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  // peripheral requests
  input wire logic timer2Irq,
  input wire logic timer1Irq,
  input wire logic timer0Irq,
  input wire logic uart0RxIrq,
  input wire logic uart0TxIrq,
  input wire logic i2cIrq,
  input wire logic spiIrq,
  input wire logic adcIrq,
  input wire logic timer3Irq,
  input wire logic uart1RxIrq,
  input wire logic uart1TxIrq,
  input wire logic dmaIrq,
  input wire logic watchdogIrq,
  input wire logic watchdogIrqEnable,
  // gpio pins and edge configuration
  input wire logic [7:0] portAIn,
  input wire logic [7:0] portDIn,
  input wire logic [3:0] portCIn,
  input wire logic [7:0] irqPortSelect,
  input wire logic [7:0] irqFallingEdge,
  // core events
  input wire logic enable_irq_instr,
  input wire logic disable_irq_instr,
  input wire logic return_from_irq_instr,
  input wire logic trapInstr,
  input wire logic illegalInstrTrap,
  input wire logic irqAck,
  // software writes
  input wire logic masterEnableWrite,
  input wire logic masterEnableWdata,
  input wire logic [2:0] pendingWrite,
  input wire logic [2:0] enableHighWrite,
  input wire logic [2:0] enableLowWrite,
  input wire logic [7:0] regWdata,
  // outputs
  output logic master_irq_enable,
  output logic irqRequest,
  output logic [15:0] irqVectorMsbAddr,
  output logic [15:0] irqVectorLsbAddr,
  output logic [7:0] group0_pending_bits,
  output logic [7:0] group1_pending_bits,
  output logic [7:0] group2_pending_bits,
  output logic [7:0] group0_enable_high_bits,
  output logic [7:0] group0_enable_low_bits,
  output logic [7:0] group1EnableHighBits,
  output logic [7:0] group1EnableLowBits,
  output logic [7:0] group2EnableHighBits,
  output logic [7:0] group2EnableLowBits
);

  // ************************************************************
  // state
  // ************************************************************
  logic [23:0] pendQ;
  logic [23:0] pendD;
  logic [23:0] enHighQ;
  logic [23:0] enHighD;
  logic [23:0] enLowQ;
  logic [23:0] enLowD;
  logic masterQ;
  logic masterD;
  offer_state_type stateQ;
  offer_state_type stateD;
  logic [15:0] vectorQ;
  logic [15:0] vectorD;
  logic [4:0] winPosQ;
  logic [4:0] winPosD;
  logic wdtWinQ;
  logic wdtWinD;
  logic [11:0] gpioPrevQ;
  logic primedQ;

  // ************************************************************
  // gpio edge detection
  // ************************************************************
  logic [7:0] sharedPin;
  logic [7:0] sharedEdge;
  logic [3:0] portCEdge;

  assign sharedPin = (irqPortSelect & portDIn) | (~irqPortSelect & portAIn); // [R22]

  genvar gp;
  generate
    for (gp = 0; gp < GPIO_SHARED; gp++)
    begin : g_shared
      // falling select chooses the high-to-low transition
      assign sharedEdge[gp] = primedQ &
        (irqFallingEdge[gp] ? (gpioPrevQ[gp] & ~sharedPin[gp])
                            : (~gpioPrevQ[gp] & sharedPin[gp])); // [R4]
    end
    for (gp = 0; gp < GPIO_DUAL; gp++)
    begin : g_dual
      assign portCEdge[gp] = primedQ &
        (gpioPrevQ[GPIO_SHARED + gp] ^ portCIn[gp]); // [R6]
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gpioPrevQ <= 12'h000;
      primedQ <= 1'b0;
    end
    else
    begin
      gpioPrevQ <= {portCIn, sharedPin};
      primedQ <= 1'b1;
    end
  end

  // ************************************************************
  // request vector in table order, flat bit 23 is highest
  // ************************************************************
  logic [23:0] reqFlat;

  assign reqFlat = {timer2Irq, timer1Irq, timer0Irq, uart0RxIrq,
                    uart0TxIrq, i2cIrq, spiIrq, adcIrq,
                    sharedEdge,
                    timer3Irq, uart1RxIrq, uart1TxIrq, dmaIrq,
                    portCEdge}; // [R3] [R4] [R5] [R6]

  // ************************************************************
  // write decode, group g covers flat bits 23-8g down to 16-8g
  // ************************************************************
  logic [23:0] pendWrMask;
  logic [23:0] enHighWrMask;
  logic [23:0] enLowWrMask;
  logic [23:0] wdataFlat;
  logic [23:0] ackMask;
  logic ackTaken;

  assign wdataFlat = {regWdata, regWdata, regWdata};
  assign pendWrMask = {{8{pendingWrite[0]}}, {8{pendingWrite[1]}},
                       {8{pendingWrite[2]}}};
  assign enHighWrMask = {{8{enableHighWrite[0]}}, {8{enableHighWrite[1]}},
                         {8{enableHighWrite[2]}}};
  assign enLowWrMask = {{8{enableLowWrite[0]}}, {8{enableLowWrite[1]}},
                        {8{enableLowWrite[2]}}};
  assign ackTaken = irqAck && (stateQ == ST_OFFER);
  // ack only retires the latched programmable winner
  assign ackMask = (ackTaken && !wdtWinQ) ? (24'h000001 << winPosQ)
                                          : 24'h000000;

  // ************************************************************
  // pending bits
  // ************************************************************
  genvar sb;
  generate
    for (sb = 0; sb < NUM_SRC; sb++)
    begin : g_pend
      logic swClr;
      logic swSet;
      assign swClr = pendWrMask[sb] & ~wdataFlat[sb];
      assign swSet = pendWrMask[sb] & wdataFlat[sb];
      if (CONT_MASK[sb])
      begin : g_cont
        // level source: write 0 drops it one cycle, ack ignored
        assign pendD[sb] = swClr ? 1'b0
                                 : (pendQ[sb] | reqFlat[sb] | swSet); // [R7] [R16] [R17]
      end
      else
      begin : g_pulse
        // pulse source: sticky, new pulse beats any clear
        assign pendD[sb] = reqFlat[sb] | swSet |
          (pendQ[sb] & ~swClr & ~ackMask[sb]); // [R7] [R13] [R14] [R15] [R25]
      end
    end
  endgenerate

  assign enHighD = (enHighWrMask & wdataFlat) | (~enHighWrMask & enHighQ);
  assign enLowD = (enLowWrMask & wdataFlat) | (~enLowWrMask & enLowQ);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pendQ <= PEND_RESET; // [R23]
      enHighQ <= ENABLE_RESET; // [R23]
      enLowQ <= ENABLE_RESET;
    end
    else
    begin
      pendQ <= pendD; // [R21]
      enHighQ <= enHighD;
      enLowQ <= enLowD;
    end
  end

  // ************************************************************
  // master enable
  // ************************************************************
  logic masterSet;
  logic masterClr;

  assign masterSet = enable_irq_instr | return_from_irq_instr |
                     (masterEnableWrite & masterEnableWdata); // [R8]
  assign masterClr = disable_irq_instr | ackTaken | trapInstr |
                     illegalInstrTrap |
                     (masterEnableWrite & ~masterEnableWdata); // [R9]
  assign masterD = masterClr ? 1'b0 : (masterSet | masterQ);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      masterQ <= MASTER_RESET; // [R9]
    else
      masterQ <= masterD;
  end

  // ************************************************************
  // arbitration
  // ************************************************************
  logic [23:0] lvl3Mask;
  logic [23:0] lvl2Mask;
  logic [23:0] lvl1Mask;
  logic [23:0] winMask;
  logic [4:0] winPos;
  logic anyPending;
  logic wdtActive;
  logic [15:0] srcVector;

  // enable pair per source; watchdog is outside these controls
  assign lvl3Mask = pendQ & enHighQ & enLowQ; // [R19] [R20]
  assign lvl2Mask = pendQ & enHighQ & ~enLowQ; // [R20]
  assign lvl1Mask = pendQ & ~enHighQ & enLowQ; // [R20]
  assign winMask = (|lvl3Mask) ? lvl3Mask :
                   (|lvl2Mask) ? lvl2Mask : lvl1Mask; // [R10]
  assign anyPending = |winMask;
  assign wdtActive = watchdogIrq & watchdogIrqEnable; // [R19]

  // highest flat bit is the lowest vector address
  function automatic logic [4:0] top_bit(input logic [23:0] mask);
    logic [4:0] pos;
    pos = 5'h00;
    for (int i = 0; i < NUM_SRC; i++)
      if (mask[i])
        pos = 5'(i);
    return pos;
  endfunction

  assign winPos = top_bit(winMask); // [R11]
  assign srcVector = VEC_FIRST_SRC +
    16'(VEC_STEP * 16'(5'(NUM_SRC - 1) - winPos)); // [R3] [R11]

  // ************************************************************
  // offer to the core
  // ************************************************************
  logic candidate;

  assign candidate = masterQ & (wdtActive | anyPending); // [R21]

  always_comb
  begin
    stateD = stateQ;
    vectorD = vectorQ;
    winPosD = winPosQ;
    wdtWinD = wdtWinQ;
    unique case (stateQ)
      ST_IDLE:
      begin
        if (candidate)
        begin
          stateD = ST_OFFER;
          wdtWinD = wdtActive; // [R12]
          winPosD = winPos;
          vectorD = wdtActive ? VEC_WATCHDOG : srcVector; // [R2] [R12]
        end
      end
      ST_OFFER:
      begin
        // held until ack; withdrawn if software drops the master enable
        if (ackTaken || !masterQ)
          stateD = ST_IDLE; // [R24]
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stateQ <= ST_IDLE;
      vectorQ <= VECTOR_RESET;
      winPosQ <= 5'h00;
      wdtWinQ <= 1'b0;
    end
    else
    begin
      stateQ <= stateD;
      vectorQ <= vectorD; // [R24]
      winPosQ <= winPosD;
      wdtWinQ <= wdtWinD;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign irqRequest = (stateQ == ST_OFFER); // [R24]
  assign irqVectorMsbAddr = vectorQ; // [R1]
  assign irqVectorLsbAddr = vectorQ | VEC_LSB_OFFSET; // [R1]
  assign master_irq_enable = masterQ;
  assign group0_pending_bits = pendQ[23:16];
  assign group1_pending_bits = pendQ[15:8];
  assign group2_pending_bits = pendQ[7:0];
  assign group0_enable_high_bits = enHighQ[23:16];
  assign group0_enable_low_bits = enLowQ[23:16];
  assign group1EnableHighBits = enHighQ[15:8];
  assign group1EnableLowBits = enLowQ[15:8];
  assign group2EnableHighBits = enHighQ[7:0];
  assign group2EnableLowBits = enLowQ[7:0];

endmodule

// ===== hdl/irq_ctrl_pkg.sv
// package for the prioritized vectored interrupt controller
// assumes one system clock; source numbering follows the vector table order
package irq_ctrl_pkg;

  // ************************************************************
  // source numbering and widths
  // ************************************************************
  localparam int NUM_SRC = 24;
  localparam int GROUP_W = 8;
  localparam int NUM_GROUPS = 3;
  localparam int GPIO_SHARED = 8;
  localparam int GPIO_DUAL = 4;
  localparam int SRC_IDX_W = 5;
  localparam int VEC_W = 16;

  // ************************************************************
  // fixed program-memory vector addresses (msb at even, lsb at odd)
  // ************************************************************
  localparam logic [15:0] VEC_RESET = 16'h0002;
  localparam logic [15:0] VEC_WATCHDOG = 16'h0004;
  localparam logic [15:0] VEC_ILLEGAL_TRAP = 16'h0006;
  localparam logic [15:0] VEC_FIRST_SRC = 16'h0008;
  localparam logic [15:0] VEC_LAST_GROUP0 = 16'h0016;
  localparam logic [15:0] VEC_GPIO_PIN7 = 16'h0018;
  localparam logic [15:0] VEC_GPIO_PIN0 = 16'h0026;
  localparam logic [15:0] VEC_TIMER3 = 16'h0028;
  localparam logic [15:0] VEC_DMA = 16'h002E;
  localparam logic [15:0] VEC_PORTC3 = 16'h0030;
  localparam logic [15:0] VEC_PORTC0 = 16'h0036;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam logic [15:0] VEC_LSB_OFFSET = 16'h0001;

  // ************************************************************
  // assertion types: 1 marks a continuous-assertion source
  // flat bit 23 is group 0 bit 7 (highest priority source)
  // ************************************************************
  localparam logic [23:0] CONT_MASK = 24'h1E0060;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [23:0] PEND_RESET = 24'h000000;
  localparam logic [23:0] ENABLE_RESET = 24'h000000;
  localparam logic [15:0] VECTOR_RESET = 16'h0000;
  localparam logic MASTER_RESET = 1'b0;

  // ************************************************************
  // priority levels from {enable high, enable low}
  // ************************************************************
  localparam logic [1:0] LEVEL_OFF = 2'h0;
  localparam logic [1:0] LEVEL_1 = 2'h1;
  localparam logic [1:0] LEVEL_2 = 2'h2;
  localparam logic [1:0] LEVEL_3 = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_OFFER = 2'b10
  } offer_state_type;

endpackage

// ===== tb/core_model.sv
// processor core stand-in: acknowledges an offered vector after a delay
// assumes irqRequest is registered in the controller on the same clock
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic irqRequest,
  input wire logic [1:0] ackDelay,
  output logic irqAck
);
  logic [1:0] wait_q;

  // one-cycle acknowledge, raised only while an offer stands
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wait_q <= 2'h0;
      irqAck <= 1'b0;
    end
    else if (irqAck || !irqRequest)
    begin
      wait_q <= 2'h0;
      irqAck <= 1'b0;
    end
    else if (wait_q == ackDelay)
      irqAck <= 1'b1;
    else
      wait_q <= wait_q + 2'h1;
  end
endmodule

// ===== tb/irq_ctrl_properties.sv
// port-level assertions for the vectored interrupt controller
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/1ps
module irq_ctrl_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic timer2Irq,
  input wire logic uart0RxIrq,
  input wire logic watchdogIrq,
  input wire logic watchdogIrqEnable,
  input wire logic enable_irq_instr,
  input wire logic disable_irq_instr,
  input wire logic return_from_irq_instr,
  input wire logic trapInstr,
  input wire logic illegalInstrTrap,
  input wire logic irqAck,
  input wire logic masterEnableWrite,
  input wire logic masterEnableWdata,
  input wire logic [2:0] pendingWrite,
  input wire logic [7:0] regWdata,
  input wire logic master_irq_enable,
  input wire logic irqRequest,
  input wire logic [15:0] irqVectorMsbAddr,
  input wire logic [15:0] irqVectorLsbAddr,
  input wire logic [7:0] group0_pending_bits
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic clrEv = disable_irq_instr | trapInstr | illegalInstrTrap |
    (irqAck & irqRequest) | (masterEnableWrite & ~masterEnableWdata);
  wire logic setEv = enable_irq_instr | return_from_irq_instr |
    (masterEnableWrite & masterEnableWdata);
  wire logic wdogOn = watchdogIrq & watchdogIrqEnable;
  wire logic clrT2 = pendingWrite[0] & ~regWdata[7];
  wire logic clrU0 = pendingWrite[0] & ~regWdata[4];

  a_master_set: assert property (setEv && !clrEv |=> master_irq_enable)
    else $error("master enable not set");
  a_master_clear: assert property (clrEv |=> !master_irq_enable)
    else $error("master enable not cleared");
  a_ack_ends: assert property (irqRequest && irqAck |=> !irqRequest)
    else $error("offer not withdrawn after acknowledge");
  a_offer_held: assert property (irqRequest && !clrEv
    && master_irq_enable |=> irqRequest && $stable(irqVectorMsbAddr))
    else $error("offer dropped or vector moved");
  a_no_forward: assert property (!master_irq_enable |=> !irqRequest)
    else $error("request forwarded while disabled");
  a_watchdog_first: assert property (master_irq_enable && !irqRequest &&
    wdogOn && !clrEv |=> irqRequest && irqVectorMsbAddr == 16'h0004)
    else $error("watchdog vector not offered");
  a_vector_pair: assert property (irqVectorLsbAddr ==
    (irqVectorMsbAddr | 16'h0001))
    else $error("low byte address not the odd neighbour");
  a_pulse_capture: assert property (timer2Irq |=> group0_pending_bits[7])
    else $error("pulse not captured");
  a_pulse_write0: assert property (clrT2 && !timer2Irq
    |=> !group0_pending_bits[7])
    else $error("pulse pending not cleared by write");
  a_level_write0: assert property (clrU0 |=> !group0_pending_bits[4])
    else $error("level pending not cleared for one cycle");
  a_level_sets: assert property (uart0RxIrq && !clrU0
    |=> group0_pending_bits[4])
    else $error("level pending not held");

  c_ack: cover property (irqRequest && irqAck);
  c_level_rewrite: cover property (clrU0 && uart0RxIrq);
  c_watchdog: cover property (master_irq_enable && wdogOn && !irqRequest);
endmodule

bind prioritized_vector_irq_controller irq_ctrl_properties i_props (
  .clk, .arst_n, .timer2Irq, .uart0RxIrq, .watchdogIrq, .watchdogIrqEnable,
  .enable_irq_instr, .disable_irq_instr, .return_from_irq_instr, .trapInstr,
  .illegalInstrTrap, .irqAck, .masterEnableWrite, .masterEnableWdata,
  .pendingWrite, .regWdata, .master_irq_enable, .irqRequest,
  .irqVectorMsbAddr, .irqVectorLsbAddr, .group0_pending_bits);

// ===== tb/prioritized_vector_irq_controller_bench.sv
// self-checking bench for the vectored interrupt controller
// assumes the package, the controller, its bound checker and core_model
`timescale 1ns/1ps
`define CHK(nm, e, s) \
  begin \
    checksDone++; \
    if ((s) !== (e)) \
    begin \
      miscompares++; \
      $display("Error %s expected %0h seen %0h", nm, e, s); \
    end \
  end
module prioritized_vector_irq_controller_bench
  import irq_ctrl_pkg::*;
;
  localparam logic [23:0] contSrc = 24'h1E0060;
  logic clk = 1'b0, arst_n = 1'b0, mwd = 1'b0, wdog = 1'b0, wdogEn = 1'b0;
  logic [23:0] src = 24'h000000, eH, eL;
  logic [7:0] portD = 8'h5A, sel = 8'h00, fall = 8'h00, wdat = 8'h00;
  logic [5:0] ev = 6'h00;
  logic [2:0] pw = 3'h0, ehw = 3'h0, elw = 3'h0;
  logic [1:0] ackDly = 2'h0;
  logic [15:0] expV;
  logic [5:0] evTab [7] = '{6'h01, 6'h02, 6'h20, 6'h04, 6'h08, 6'h10, 6'h20};
  wire logic ack, mEn, req;
  wire logic [15:0] vMsb, vLsb;
  wire logic [23:0] pend, enh, enl;
  int seed = 46884, miscompares = 0, checksDone = 0, i, j, li, lj, w;

  prioritized_vector_irq_controller i_dut (
    .clk(clk), .arst_n(arst_n), .timer2Irq(src[23]), .timer1Irq(src[22]),
    .timer0Irq(src[21]), .uart0RxIrq(src[20]), .uart0TxIrq(src[19]),
    .i2cIrq(src[18]), .spiIrq(src[17]), .adcIrq(src[16]),
    .timer3Irq(src[7]), .uart1RxIrq(src[6]), .uart1TxIrq(src[5]),
    .dmaIrq(src[4]), .watchdogIrq(wdog), .watchdogIrqEnable(wdogEn),
    .portAIn(src[15:8]), .portDIn(portD), .portCIn(src[3:0]),
    .irqPortSelect(sel), .irqFallingEdge(fall),
    .enable_irq_instr(ev[0]), .return_from_irq_instr(ev[1]),
    .disable_irq_instr(ev[2]), .trapInstr(ev[3]), .illegalInstrTrap(ev[4]),
    .irqAck(ack), .masterEnableWrite(ev[5]), .masterEnableWdata(mwd),
    .pendingWrite(pw), .enableHighWrite(ehw), .enableLowWrite(elw),
    .regWdata(wdat), .master_irq_enable(mEn), .irqRequest(req),
    .irqVectorMsbAddr(vMsb), .irqVectorLsbAddr(vLsb),
    .group0_pending_bits(pend[23:16]), .group1_pending_bits(pend[15:8]),
    .group2_pending_bits(pend[7:0]), .group0_enable_high_bits(enh[23:16]),
    .group0_enable_low_bits(enl[23:16]), .group1EnableHighBits(enh[15:8]),
    .group1EnableLowBits(enl[15:8]), .group2EnableHighBits(enh[7:0]),
    .group2EnableLowBits(enl[7:0]));
  core_model i_core (.clk(clk), .arst_n(arst_n), .irqRequest(req),
    .ackDelay(ackDly), .irqAck(ack));

  always #12.5 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // strobes {pending, enable high, enable low}; left as given for the next
  task automatic wr(input logic [8:0] s, input logic [7:0] d);
    {pw, ehw, elw} = s;
    wdat = d;
    tick(1);
  endtask
  task automatic pulse(input logic [5:0] e);
    ev = e;
    tick(1);
    ev = 6'h00;
    tick(1);
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic waitReq(input logic lvl);
    int t;
    t = 0;
    while (req !== lvl && t < 20)
    begin
      tick(1);
      t++;
    end
    if (req !== lvl)
    begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic resetChk();
    `CHK("pending", 24'h000000, pend);
    `CHK("enable high", 24'h000000, enh);
    `CHK("enable low", 24'h000000, enl);
    `CHK("master", 1'b0, mEn);
    `CHK("low vector", 16'h0001, vLsb);
  endtask
  function automatic int winner(int a, int b, int la, int lb);
    return (lb > la || (lb == la && b > a)) ? b : a;
  endfunction

  initial
  begin
    fall = 8'($random(seed));
    tick(10);
    resetChk();
    arst_n = 1'b1;
    tick(2);
    for (int k = 0; k < 7; k++)
    begin
      pulse((k < 3) ? 6'h04 : 6'h01);
      mwd = (k < 3);
      pulse(evTab[k]);
      `CHK("master", k < 3, mEn);
    end
    pulse(6'h05);
    `CHK("master both", 1'b0, mEn);
    sel = 8'hFF;
    tick(3);
    wr(9'h080, 8'h00);
    wr(9'h000, 8'h00);
    src[15:8] = 8'hFF;
    tick(1);
    src[15:8] = 8'h00;
    tick(4);
    `CHK("unselected port", 8'h00, pend[15:8]);
    portD = ~portD;
    tick(1);
    portD = ~portD;
    tick(4);
    `CHK("selected port", 8'hFF, pend[15:8]);
    // one transition per pin: only the chosen edge direction may latch
    wr(9'h080, 8'h00);
    wr(9'h000, 8'h00);
    portD = ~portD;
    tick(4);
    `CHK("edge select", portD ^ fall, pend[15:8]);
    sel = 8'h00;
    tick(3);
    wr(9'h080, 8'h00);
    for (int n = 0; n < 40; n++)
    begin
      i = (n < 24) ? n : {$random(seed)} % 24;
      j = {$random(seed)} % 24;
      li = 1 + {$random(seed)} % 3;
      lj = (i == j) ? li : 1 + {$random(seed)} % 3;
      {wdog, wdogEn, ackDly} = 4'($random(seed));
      eH = 24'h000000;
      eL = 24'h000000;
      {eH[i], eL[i]} = 2'(li);
      {eH[j], eL[j]} = 2'(lj);
      for (int g = 0; g < 3; g++)
      begin
        wr(9'(1 << (g + 3)), eH[(2 - g) * 8 +: 8]);
        wr(9'(1 << g), eL[(2 - g) * 8 +: 8]);
      end
      wr(9'h000, 8'h00);
      `CHK("enable high", eH, enh);
      `CHK("enable low", eL, enl);
      src = (24'h000001 << i) | (24'h000001 << j);
      tick(1);
      src = src & contSrc;
      tick(4);
      `CHK("pending", 2'b11, {pend[i], pend[j]});
      `CHK("polled only", 1'b0, req);
      pulse(6'h01);
      waitReq(1'b1);
      w = winner(i, j, li, lj);
      expV = (wdog & wdogEn) ? 16'h0004 : 16'h0008 + 16'((23 - w) * 2);
      `CHK("vector", expV, vMsb);
      `CHK("low vector", expV | 16'h0001, vLsb);
      waitReq(1'b0);
      `CHK("master after ack", 1'b0, mEn);
      `CHK("kept", contSrc[i] | (wdog & wdogEn) | (w != i), pend[i]);
      if (contSrc[i])
      begin
        wr(9'(1 << (8 - i / 8)),
          pend[(i / 8) * 8 +: 8] & ~(8'h01 << (i % 8)));
        `CHK("level cleared", 1'b0, pend[i]);
        wr(9'h000, 8'h00);
        `CHK("level again", 1'b1, pend[i]);
      end
      // sources go quiet before their pending bits are cleared
      src = 24'h000000;
      wdog = 1'b0;
      wr(9'h1C0, 8'h00);
      `CHK("cleared", 24'h000000, pend);
      wr(9'h000, 8'h00);
    end
    pulse(6'h01);
    src[23] = 1'b1;
    tick(1);
    src[23] = 1'b0;
    tick(1);
    arst_n = 1'b0;
    tick(2);
    resetChk();
    arst_n = 1'b1;
    tick(2);
    give_verdict();
  end
endmodule
